// ---- common/fault_log_pkg.sv ----
// Constants and types for the fault-log block formatter
package fault_log_pkg;
    // Clock and shared-clock timestamp tick
    localparam int CLK_MHZ = 100;
    localparam int TICK_TIME_US = 200;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
    localparam int TS_WIDTH = 41;
    // Block layout, byte indices
    localparam logic [7:0] IDX_PTR = 8'h00;
    localparam logic [7:0] IDX_VALID = 8'h01;
    localparam logic [7:0] TS_FIRST = 8'h02;
    localparam logic [7:0] PM_FIRST = 8'h08;
    localparam logic [7:0] TEMP_FIRST = 8'h1c;
    localparam logic [7:0] STAT_FIRST = 8'h30;
    localparam logic [7:0] CYC_FIRST = 8'h48;
    localparam logic [7:0] CYC_LAST = 8'hed;
    localparam logic [7:0] RSV_LAST = 8'hfe;
    // Cyclic loop and history depth
    localparam logic [7:0] LOOP_LEN = 8'h2e;
    localparam logic [7:0] CYC_DEPTH = 8'ha6;
    // Peak/min slots: ch0 ch1 vin ch2 ch3 temp ch4..ch7
    localparam int PM_SLOTS = 10;
    localparam int TEMP_SLOT = 5;
    localparam int CHANNELS = 8;
    localparam int STAT_BYTES = 3;
    // Fixed byte values
    localparam logic [7:0] BYTE_COUNT = 8'hff;
    localparam logic [7:0] ALL_VALID = 8'hff;
    localparam logic [7:0] RSV_FILL = 8'h00;
    // Read sequencer, Gray along idle-count-data
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_DATA = 2'b11
    } rd_state_t;
endpackage

// ---- dv/pmbus_reader.sv ----
// Block-read host model: starts a read, accepts and keeps every byte
`timescale 1ns/1ps
module pmbus_reader
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic [7:0] data_i,
    input wire logic valid_i,
    input wire logic busy_i,
    input wire logic [7:0] pos_i,
    output logic start_o,
    output logic ack_o
);
    logic [7:0] blk [0:255];
    logic [7:0] cpos [0:255];
    int n = 0;
    initial
    begin
        start_o = 1'b0;
        ack_o = 1'b0;
    end
    // Drive on the falling edge; slow mode stalls acks at random
    always @(negedge clk_i)
    begin
        start_o <= go_i && !busy_i && !start_o;
        ack_o <= valid_i && (!slow_i || ($urandom_range(0, 2) == 0));
    end
    // Slot 0 holds the count, slot n holds block index n-1
    always @(posedge clk_i)
    begin
        if (start_o)
            n <= 0;
        else if (valid_i && ack_o)
        begin
            blk[n] <= data_i;
            cpos[n] <= pos_i;
            n <= n + 1;
        end
    end
endmodule // pmbus_reader

// ---- dv/testbench.sv ----
// Self-checking bench for the fault-log block formatter
`timescale 1ns/1ps
module testbench;
    import fault_log_pkg::*;
    localparam int TICKS = 20;
    logic clk = 0, rst = 1, sv = 0, lock = 0, fault = 0, go = 0, slow = 0;
    logic start, ack, dv, busy;
    logic [7:0] smp = 0, dat, cpos, e_ptr, e_cnt;
    logic [159:0] peak = 0, mn = 0, e_peak, e_min;
    logic [63:0] vo = 0, vd = 0, e_vo, e_vd;
    logic [127:0] ex = 0, e_ex;
    logic [7:0] hist [$];
    int n_errors = 0, tests_run = 0, cyc = 0, e_cyc = 0, rst_cyc = 0, wr = 0;
    fault_log_block_formatter #(.TICK_CYCLES(TICKS)) u_dut
    (
        .CLK_SYS_I(clk), .RST_I(rst), .SAMPLE_VALID_I(sv), .SAMPLE_I(smp),
        .LOCK_I(lock), .FAULT_I(fault), .PEAK_I(peak), .MIN_I(mn),
        .VOUT_STATUS_I(vo), .VENDOR_STATUS_I(vd), .EXT_STATUS_I(ex),
        .READ_START_I(start), .READ_ACK_I(ack), .DATA_O(dat),
        .DATA_VALID_O(dv), .CYC_POS_O(cpos), .BUSY_O(busy)
    );
    pmbus_reader h
    (
        .clk_i(clk), .go_i(go), .slow_i(slow), .data_i(dat), .valid_i(dv),
        .busy_i(busy), .pos_i(cpos), .start_o(start), .ack_o(ack)
    );
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Hang guard, well above the four reads and fills
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask
    // Expected block byte from the snapshot and the sample history
    function automatic logic [7:0] exp_byte(int b);
        int s;
        logic [15:0] w;
        s = (b < 8) ? 0 : (b < 48) ? (b - 8) / 4
            : (b < 72) ? (b - 48) / 3 : 0;
        w = (b % 4 < 2) ? e_peak[s*16+:16] : e_min[s*16+:16];
        if (b == 0)
            return e_ptr;
        if (b == 1)
            return e_cnt;
        if (b < 48)
            return (b % 2) ? w[15:8] : w[7:0];
        if (b < 72)
            return ((b - 48) % 3 == 0) ? e_vo[s*8+:8] :
                ((b - 48) % 3 == 1) ? e_vd[s*8+:8] : e_ex[s*16+:8];
        if (b > 237)
            return RSV_FILL;
        return hist[b - 72];
    endfunction
    // Samples in loop order; with may_lock some are dropped
    task automatic feed(int cnt, bit may_lock);
        for (int j = 0; j < cnt; j++)
        begin
            @(negedge clk);
            sv = 1'b1;
            smp = 8'($urandom);
            lock = may_lock && ($urandom_range(0, 3) == 0);
            if (!lock)
            begin
                hist.push_front(smp);
                wr++;
            end
        end
        @(negedge clk);
        sv = 1'b0;
        lock = 1'b0;
    endtask
    // Snapshot taken, then inputs flipped so a stale copy shows
    task automatic capture();
        peak = {$urandom, $urandom, $urandom, $urandom, $urandom};
        mn = {$urandom, $urandom, $urandom, $urandom, $urandom};
        vo = {$urandom, $urandom};
        vd = {$urandom, $urandom};
        ex = {$urandom, $urandom, $urandom, $urandom};
        e_peak = peak;
        e_min = mn;
        e_vo = vo;
        e_vd = vd;
        e_ex = ex;
        e_ptr = 8'((wr - 1) % 46);
        e_cnt = (wr >= 166) ? ALL_VALID : 8'(wr);
        e_cyc = cyc - rst_cyc;
        fault = 1'b1;
        @(negedge clk);
        fault = 1'b0;
        peak = ~peak;
        mn = ~mn;
        vo = ~vo;
        vd = ~vd;
        ex = ~ex;
    endtask
    task automatic verify();
        longint d;
        int b;
        d = longint'({h.blk[8][0], h.blk[7], h.blk[6], h.blk[5], h.blk[4],
            h.blk[3]}) - e_cyc / TICKS;
        check("byte count", h.blk[0], BYTE_COUNT);
        check("stamp top", {1'b0, h.blk[8][7:1]}, 8'h00);
        check("stamp", {7'h0, d >= -1 && d <= 1}, 8'h01);
        for (int i = 1; i < 256; i++)
        begin
            b = i - 1;
            if ((b < 2 || b > 7) && (b < 72 || b > 237 || b - 72 < hist.size()))
                check("byte", h.blk[i], exp_byte(b));
            if (b >= 72 && b <= 237)
                check("pos", h.cpos[i], 8'((e_ptr + 256 - b) % 46));
        end
    endtask
    // Slow reads also try a capture mid-read, which must be ignored
    task automatic read_block(bit s);
        slow = s;
        go = 1'b1;
        wait (busy === 1'b1);
        @(negedge clk);
        go = 1'b0;
        fault = s;
        @(negedge clk);
        fault = 1'b0;
        wait (h.n == 256);
        @(negedge clk);
        check("busy end", {6'h0, busy, dv}, 8'h00);
        verify();
    endtask
    initial
    begin
        void'($urandom(32'h1f07));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rst_cyc = cyc;
        feed(50, 1'b0);
        capture();
        read_block(1'b0);
        feed(300, 1'b1);
        capture();
        read_block(1'b1);
        read_block(1'b0);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rst_cyc = cyc;
        hist.delete();
        wr = 0;
        feed(5, 1'b0);
        capture();
        read_block(1'b0);
        give_verdict();
    end
endmodule // testbench

// ---- logic/fault_log_block_formatter.sv ----
// Fault-log block formatter: capture, history ring and block read stream
`timescale 1ns/1ps
module fault_log_block_formatter
#(
    parameter int TICK_CYCLES = fault_log_pkg::TICK_CYCLES
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic SAMPLE_VALID_I,
    input wire logic [7:0] SAMPLE_I,
    input wire logic LOCK_I,
    input wire logic FAULT_I,
    input wire logic [fault_log_pkg::PM_SLOTS*16-1:0] PEAK_I,
    input wire logic [fault_log_pkg::PM_SLOTS*16-1:0] MIN_I,
    input wire logic [fault_log_pkg::CHANNELS*8-1:0] VOUT_STATUS_I,
    input wire logic [fault_log_pkg::CHANNELS*8-1:0] VENDOR_STATUS_I,
    input wire logic [fault_log_pkg::CHANNELS*16-1:0] EXT_STATUS_I,
    input wire logic READ_START_I,
    input wire logic READ_ACK_I,
    output logic [7:0] DATA_O,
    output logic DATA_VALID_O,
    output logic [7:0] CYC_POS_O,
    output logic BUSY_O
);
    import fault_log_pkg::*;

    localparam int STAT_W = CHANNELS * STAT_BYTES * 8;

    logic [7:0] ring [CYC_DEPTH];
    logic [7:0] wr_addr;
    logic [7:0] wr_pos;
    logic [7:0] last_addr;
    logic [7:0] last_pos;
    logic [7:0] fill_cnt;
    logic [31:0] pre;
    logic [TS_WIDTH-1:0] ts;
    logic [7:0] snap_ptr;
    logic [7:0] snap_addr;
    logic [7:0] snap_valid;
    logic [TS_WIDTH-1:0] snap_ts;
    logic [PM_SLOTS*16-1:0] snap_peak;
    logic [PM_SLOTS*16-1:0] snap_min;
    logic [STAT_W-1:0] snap_stat;
    logic [STAT_W-1:0] stat_in;
    logic [47:0] ts_pad;
    rd_state_t state;
    logic [7:0] cur_idx;
    logic [7:0] next_idx;
    logic [7:0] next_byte;
    logic [7:0] pm_off;
    logic [15:0] pm_word;
    logic [8:0] rd_sum;
    logic [7:0] rd_addr;
    logic load;
    logic capture;

    // Capture is refused mid-read so the host sees one coherent block
    assign capture = FAULT_I && (state == ST_IDLE);
    assign load = READ_ACK_I && ((state == ST_COUNT)
        || ((state == ST_DATA) && (cur_idx != RSV_LAST)));
    assign next_idx = (state == ST_DATA) ? cur_idx + 8'h01 : IDX_PTR;

    // Per-channel status triplet, upper extended byte dropped
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_stat
        assign stat_in[c*24 +: 8] = VOUT_STATUS_I[c*8 +: 8];
        assign stat_in[c*24+8 +: 8] = VENDOR_STATUS_I[c*8 +: 8];
        assign stat_in[c*24+16 +: 8] = EXT_STATUS_I[c*16 +: 8];
    end

    // History ring; samples arrive in loop order 0..45
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SAMPLE_VALID_I && !LOCK_I)
        begin
            ring[wr_addr] <= SAMPLE_I;
        end
    end

    // Write pointers, loop position and fill level
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            wr_addr <= 8'h00;
            wr_pos <= 8'h00;
            last_addr <= 8'h00;
            last_pos <= 8'h00;
            fill_cnt <= 8'h00;
        end
        else if (SAMPLE_VALID_I && !LOCK_I)
        begin
            last_addr <= wr_addr;
            last_pos <= wr_pos;
            // Depth of 166 holds 3.6 loops; oldest one is partial
            wr_addr <= (wr_addr == CYC_DEPTH - 8'h01) ? 8'h00
                : wr_addr + 8'h01;
            wr_pos <= (wr_pos == LOOP_LEN - 8'h01) ? 8'h00
                : wr_pos + 8'h01;
            if (fill_cnt != CYC_DEPTH)
            begin
                fill_cnt <= fill_cnt + 8'h01;
            end
        end
    end

    // Shared-clock timestamp, one step per tick period
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            pre <= 32'h0;
            ts <= '0;
        end
        else if (pre == 32'(TICK_CYCLES - 1))
        begin
            pre <= 32'h0;
            ts <= ts + 41'h1;
        end
        else
        begin
            pre <= pre + 32'h1;
        end
    end

    // Snapshot of pointer, count, time and preamble values at a fault
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            snap_ptr <= 8'h00;
            snap_addr <= 8'h00;
            snap_valid <= 8'h00;
            snap_ts <= '0;
            snap_peak <= '0;
            snap_min <= '0;
            snap_stat <= '0;
        end
        else if (capture)
        begin
            snap_ptr <= last_pos;
            snap_addr <= last_addr;
            snap_valid <= (fill_cnt == CYC_DEPTH) ? ALL_VALID
                : fill_cnt;
            snap_ts <= ts;
            snap_peak <= PEAK_I;
            snap_min <= MIN_I;
            snap_stat <= stat_in;
        end
    end

    // Byte selection for the next index of the block
    always_comb
    begin
        next_byte = RSV_FILL;
        ts_pad = {7'h0, snap_ts};
        pm_off = next_idx - PM_FIRST;
        pm_word = pm_off[1] ? snap_min[int'(pm_off[7:2])*16 +: 16]
            : snap_peak[int'(pm_off[7:2])*16 +: 16];
        // Walk backwards from the snapshot, modulo the ring depth
        rd_sum = {1'b0, snap_addr} + {1'b0, CYC_DEPTH}
            - {1'b0, next_idx - CYC_FIRST};
        if (rd_sum >= {1'b0, CYC_DEPTH})
        begin
            rd_sum = rd_sum - {1'b0, CYC_DEPTH};
        end
        rd_addr = rd_sum[7:0];
        if (next_idx == IDX_PTR)
        begin
            next_byte = snap_ptr;
        end
        else if (next_idx == IDX_VALID)
        begin
            next_byte = snap_valid;
        end
        else if (next_idx < PM_FIRST)
        begin
            next_byte = ts_pad[int'(next_idx - TS_FIRST)*8 +: 8];
        end
        else if (next_idx < STAT_FIRST)
        begin
            next_byte = pm_off[0] ? pm_word[15:8] : pm_word[7:0];
        end
        else if (next_idx < CYC_FIRST)
        begin
            next_byte = snap_stat[int'(next_idx - STAT_FIRST)*8 +: 8];
        end
        else if (next_idx <= CYC_LAST)
        begin
            next_byte = ring[rd_addr];
        end
    end

    // Block read sequencer; DATA_O holds until the host acks
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            state <= ST_IDLE;
            DATA_O <= 8'h00;
            DATA_VALID_O <= 1'b0;
            cur_idx <= 8'h00;
            BUSY_O <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (READ_START_I)
                    begin
                        DATA_O <= BYTE_COUNT;
                        DATA_VALID_O <= 1'b1;
                        BUSY_O <= 1'b1;
                        state <= ST_COUNT;
                    end
                end
                ST_COUNT:
                begin
                    if (READ_ACK_I)
                    begin
                        // Bus byte one is block index zero
                        DATA_O <= next_byte;
                        cur_idx <= next_idx;
                        state <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (READ_ACK_I && (cur_idx == RSV_LAST))
                    begin
                        DATA_VALID_O <= 1'b0;
                        BUSY_O <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else if (READ_ACK_I)
                    begin
                        DATA_O <= next_byte;
                        cur_idx <= next_idx;
                    end
                end
                default:
                begin
                    DATA_VALID_O <= 1'b0;
                    BUSY_O <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Loop position of the cyclic byte on DATA_O
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            CYC_POS_O <= 8'h00;
        end
        else if (load && (next_idx == CYC_FIRST))
        begin
            CYC_POS_O <= snap_ptr;
        end
        else if (load && (next_idx > CYC_FIRST) && (next_idx <= CYC_LAST))
        begin
            CYC_POS_O <= (CYC_POS_O == 8'h00) ? LOOP_LEN - 8'h01
                : CYC_POS_O - 8'h01;
        end
    end

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    sequence s_start;
        (state == ST_IDLE) && READ_START_I;
    endsequence
    sequence s_count_out;
        DATA_VALID_O && (DATA_O == BYTE_COUNT) && (state == ST_COUNT);
    endsequence
    sequence s_cyc_step;
        load && (next_idx > CYC_FIRST) && (next_idx <= CYC_LAST);
    endsequence

    AST_COUNT_FIRST: assert property (s_start |=> s_count_out)
        else $error("byte count not sent first");
    AST_PTR_NEXT: assert property ((state == ST_COUNT) && READ_ACK_I
        |=> (DATA_O == snap_ptr) && (cur_idx == IDX_PTR))
        else $error("pointer not first data byte");
    AST_ALL_VALID: assert property (capture && (fill_cnt == CYC_DEPTH)
        |=> snap_valid == ALL_VALID)
        else $error("full ring not reported all valid");
    AST_CYC_START: assert property (load && (next_idx == CYC_FIRST)
        |=> CYC_POS_O == $past(snap_ptr))
        else $error("cyclic start not at pointer");
    AST_POS_WRAP: assert property (s_cyc_step and (CYC_POS_O == 8'h00)
        |=> CYC_POS_O == LOOP_LEN - 8'h01)
        else $error("position did not wrap to 45");
    AST_POS_STEP: assert property (s_cyc_step and (CYC_POS_O != 8'h00)
        |=> CYC_POS_O == $past(CYC_POS_O) - 8'h01)
        else $error("position did not step down");
    AST_RESERVED: assert property (load && (next_idx > CYC_LAST)
        |=> DATA_O == RSV_FILL)
        else $error("reserved byte not zero");
    AST_LOCKED: assert property (LOCK_I
        |=> $stable(wr_addr) && $stable(fill_cnt))
        else $error("ring moved while locked");
    AST_EXT_LOW: assert property (capture
        |=> snap_stat[23:16] == $past(EXT_STATUS_I[7:0]))
        else $error("extended status low byte not kept");
    AST_TEMP_LOW: assert property (load && (next_idx == TEMP_FIRST)
        |=> DATA_O == snap_peak[TEMP_SLOT*16 +: 8])
        else $error("temperature peak low byte misplaced");
    AST_TS_TICK: assert property (pre == 32'(TICK_CYCLES - 1)
        |=> ts == $past(ts) + 41'h1)
        else $error("timestamp did not advance");
    AST_END_IDLE: assert property ((state == ST_DATA) && READ_ACK_I
        && (cur_idx == RSV_LAST) |=> !DATA_VALID_O && !BUSY_O)
        else $error("stream did not end after byte 255");
endmodule // fault_log_block_formatter
